// File: design/mabs_pkg.sv
// Package with register map, command codes and field layout of the command block
package mabs_pkg;
    // Wishbone word offsets (byte addresses)
    localparam logic [5:0] MABS_OFF_CMD = 6'h00;
    localparam logic [5:0] MABS_OFF_SECCNT = 6'h04;
    localparam logic [5:0] MABS_OFF_LBALO = 6'h08;
    localparam logic [5:0] MABS_OFF_LBAMID = 6'h0c;
    localparam logic [5:0] MABS_OFF_LBAHI = 6'h10;
    localparam logic [5:0] MABS_OFF_DEVICE = 6'h14;
    localparam logic [5:0] MABS_OFF_STATUS = 6'h18;
    localparam logic [5:0] MABS_OFF_ERROR = 6'h1c;
    localparam logic [5:0] MABS_OFF_CTRL = 6'h20;
    localparam logic [5:0] MABS_OFF_NATLO = 6'h24;
    localparam logic [5:0] MABS_OFF_NATHI = 6'h28;
    localparam logic [5:0] MABS_OFF_CFG = 6'h2c;
    localparam logic [5:0] MABS_OFF_MAXLO = 6'h30;
    localparam logic [5:0] MABS_OFF_MAXHI = 6'h34;
    localparam logic [5:0] MABS_OFF_W6160 = 6'h38;
    localparam logic [5:0] MABS_OFF_BLK = 6'h3c;
    // Command codes
    localparam logic [7:0] MABS_CMD_SETMAX = 8'hf9;
    localparam logic [7:0] MABS_CMD_SETMAX_EXT = 8'h37;
    localparam logic [7:0] MABS_CMD_RDNAT_EXT = 8'h27;
    localparam logic [7:0] MABS_CMD_SETMULT = 8'hc6;
    // Field positions
    localparam int MABS_DEV_LBA_BIT = 6;
    localparam int MABS_DEV_DRV_BIT = 4;
    localparam int MABS_CTRL_HOB_BIT = 7;
    localparam int MABS_ST_RDY_BIT = 6;
    localparam int MABS_ST_ERR_BIT = 0;
    localparam int MABS_ER_ABT_BIT = 2;
    // Fixed values
    localparam logic [7:0] MABS_CHS_SECT = 8'h3f;
    localparam logic [3:0] MABS_CHS_HEAD = 4'hf;
    localparam logic [47:0] MABS_LBA28_MAX = 48'h000_0fff_ffff;
    localparam logic [7:0] MABS_STATUS_RST = 8'h40;
    localparam logic [7:0] MABS_BLK_RST = 8'h00;
    localparam logic [4:0] MABS_CFG_RST = 5'h01;
    // Configuration bit positions
    localparam int MABS_CFG_SUP_BIT = 0;
    localparam int MABS_CFG_HPA28_BIT = 1;
    localparam int MABS_CFG_LOCK_BIT = 2;
    localparam int MABS_CFG_OFFS_BIT = 3;
    localparam int MABS_CFG_POR_BIT = 4;
endpackage

// File: design/mabs_shadow.sv
// Small register file holding the previous bytes of the address registers
`timescale 1ns/1ps
module mabs_shadow
    import mabs_pkg::*;
#(
    parameter int WORDS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [2:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [7:0] rdata_o
);
    typedef struct packed {
        logic [WORDS-1:0][7:0] mem;
        logic [7:0] rd;
    } mabs_shd_t;
    mabs_shd_t s_q;
    mabs_shd_t s_d;

    always_comb begin
        s_d = s_q;
        if (we_i) begin
            s_d.mem[waddr_i] = wdata_i;
        end
        s_d.rd = s_q.mem[raddr_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rd;
endmodule

// File: design/mabs_top.sv
// Task-file command block for max-address and block-size commands
// Overview of operation
// R1: Device bit L selects CHS (0) or LBA (1) address interpretation.
// R2: Device bit D selects master (0) or slave (1) drive.
// R3: 28-bit max set in LBA mode returns address bytes and head bits.
// R4: 28-bit max set in CHS mode returns 63, head 15, cylinder.
// R5: Code 37h is 48-bit max set using current and previous bytes.
// R6: 48-bit max set aborts unless directly after read native max.
// R7: Accesses beyond accepted max address are aborted.
// R8: Above 268,435,455 update words 103:100 only, else both.
// R9: Abort if unsupported, over native, 28-bit HPA, locked or frozen (frozen is not checked).
// R10: Abort non-volatile request while address-offset mode active.
// R11: Only one non-volatile 48-bit set until power-on or reset.
// R12: Non-volatile max survives power-on reset; volatile one is lost.
// R13: Previous bytes hold bits 47-24; HOB=1 reads them back.
// R14: Code C6h sets the multi-sector block size.
// R15: Block size is sectors per interrupt for multi-sector transfers.
// R16: Block size is zero and multiple disabled after reset.
// R17: Only 0, 2, 4, 8 or 16 accepted; zero disables.
// R18: Other sizes abort and disable multi-sector commands.
// R19: Abort sets error abort bit and status error, ready stays.
// R20: Track whether last command was read native max ext.
`timescale 1ns/1ps
module mabs_top
    import mabs_pkg::*;
#(
    parameter logic [47:0] NATIVE_MAX = 48'h0000_0950_f8af
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic drive_is_slave_i,
    input wire logic access_req_i,
    input wire logic [47:0] access_lba_i,
    output logic access_abort_o,
    output logic [4:0] blk_sectors_o,
    output logic multi_en_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] seccnt;
        logic [7:0] lba_lo;
        logic [7:0] lba_mid;
        logic [7:0] lba_hi;
        logic [7:0] device;
        logic [7:0] status;
        logic [7:0] error;
        logic hob;
        logic [4:0] cfg;
        logic [47:0] max;
        logic [47:0] nv_max;
        logic nv_valid;
        logic nv_used;
        logic [27:0] w6160;
        logic [7:0] blk;
        logic last_rdnat;
        logic abort_acc;
        logic [23:0] prev;
        logic hob_rd;
    } mabs_st_t;

    mabs_st_t s_q;
    mabs_st_t s_d;
    logic sh_we;
    logic [2:0] sh_waddr;
    logic [7:0] sh_rdata;
    logic [7:0] sh_wdata;
    logic [2:0] sh_raddr;

    function automatic logic blk_ok(input logic [7:0] v);
        blk_ok = (v == 8'h00) || (v == 8'h02) || (v == 8'h04) || (v == 8'h08) || (v == 8'h10);
    endfunction

    function automatic logic [7:0] byte_wr(input logic [7:0] old, input logic [31:0] d,
            input logic [3:0] sel);
        byte_wr = sel[0] ? d[7:0] : old;
    endfunction

    // Previous bytes shadow: index 0..2 = low, mid, high previous
    mabs_shadow #(.WORDS(8)) u_shadow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(sh_we),
        .waddr_i(sh_waddr),
        .wdata_i(sh_wdata),
        .raddr_i(sh_raddr),
        .rdata_o(sh_rdata)
    );

    logic wr;
    logic rd;
    logic [47:0] req48;
    logic [47:0] prev48;
    logic [27:0] req28;
    logic [47:0] req28w;
    logic [15:0] cyl;
    logic abort_error_bit;
    logic dev_sel;
    logic [7:0] cmd;
    logic cmd_go;

    always_comb begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
        cmd = wb_dat_i[7:0];
        sh_we = 1'b0;
        sh_waddr = 3'h0;
        sh_wdata = wb_dat_i[7:0];
        // Address the shadow from the live bus so its registered byte lines up with ack
        case (wb_adr_i)
            MABS_OFF_LBAMID: sh_raddr = 3'h1;
            MABS_OFF_LBAHI: sh_raddr = 3'h2;
            default: sh_raddr = 3'h0;
        endcase
        // Shadow keeps the byte that a new write pushes out, giving the previous copy
        if (wr && wb_sel_i[0]) begin
            if (wb_adr_i == MABS_OFF_LBALO) begin
                sh_we = 1'b1;
                sh_waddr = 3'h0;
                sh_wdata = s_q.lba_lo;
            end else if (wb_adr_i == MABS_OFF_LBAMID) begin
                sh_we = 1'b1;
                sh_waddr = 3'h1;
                sh_wdata = s_q.lba_mid;
            end else if (wb_adr_i == MABS_OFF_LBAHI) begin
                sh_we = 1'b1;
                sh_waddr = 3'h2;
                sh_wdata = s_q.lba_hi;
            end
        end
        prev48 = {s_q.prev, 24'h000000};
        req48 = {prev48[47:24], s_q.lba_hi, s_q.lba_mid, s_q.lba_lo}; // R13
        req28 = {s_q.device[3:0], s_q.lba_hi, s_q.lba_mid, s_q.lba_lo};
        req28w = {20'h00000, req28};
        cyl = {s_q.lba_hi, s_q.lba_mid};
        dev_sel = s_q.device[MABS_DEV_DRV_BIT] == drive_is_slave_i; // R2
        cmd_go = wr && wb_sel_i[0] && dev_sel && (wb_adr_i == MABS_OFF_CMD);
        abort_error_bit = 1'b0;
        s_d = s_q;
        s_d.ack = (wb_cyc_i && wb_stb_i && !s_q.ack);
        s_d.rdat = 32'h00000000;
        s_d.abort_acc = access_req_i && (access_lba_i > s_q.max); // R7
        s_d.hob_rd = 1'b0;
        // Mirror of the shadow: a set command needs all three previous bytes at once,
        // while the shadow's single read port only serves the readback
        if (sh_we) begin
            case (sh_waddr)
                3'h0: s_d.prev[7:0] = sh_wdata; // R13
                3'h1: s_d.prev[15:8] = sh_wdata;
                default: s_d.prev[23:16] = sh_wdata;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                MABS_OFF_SECCNT: s_d.seccnt = byte_wr(s_q.seccnt, wb_dat_i, wb_sel_i);
                MABS_OFF_LBALO: s_d.lba_lo = byte_wr(s_q.lba_lo, wb_dat_i, wb_sel_i);
                MABS_OFF_LBAMID: s_d.lba_mid = byte_wr(s_q.lba_mid, wb_dat_i, wb_sel_i);
                MABS_OFF_LBAHI: s_d.lba_hi = byte_wr(s_q.lba_hi, wb_dat_i, wb_sel_i);
                MABS_OFF_DEVICE: s_d.device = byte_wr(s_q.device, wb_dat_i, wb_sel_i);
                MABS_OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        s_d.hob = wb_dat_i[MABS_CTRL_HOB_BIT];
                    end
                end
                MABS_OFF_CFG: begin
                    if (wb_sel_i[0]) begin
                        s_d.cfg = wb_dat_i[4:0];
                    end
                end
                MABS_OFF_CMD: begin
                    if (wb_sel_i[0] && dev_sel) begin
                        s_d.status = MABS_STATUS_RST;
                        s_d.error = 8'h00;
                        s_d.last_rdnat = (cmd == MABS_CMD_RDNAT_EXT); // R20
                        case (cmd)
                            MABS_CMD_RDNAT_EXT: begin
                                s_d.lba_lo = NATIVE_MAX[7:0];
                                s_d.lba_mid = NATIVE_MAX[15:8];
                                s_d.lba_hi = NATIVE_MAX[23:16];
                            end
                            MABS_CMD_SETMAX_EXT: begin
                                // R9 R6 R10 R11
                                if (!s_q.cfg[MABS_CFG_SUP_BIT] || req48 > NATIVE_MAX
                                        || s_q.cfg[MABS_CFG_HPA28_BIT]
                                        || s_q.cfg[MABS_CFG_LOCK_BIT] || !s_q.last_rdnat
                                        || (s_q.seccnt[0] && s_q.cfg[MABS_CFG_OFFS_BIT])
                                        || (s_q.seccnt[0] && s_q.nv_used)) begin
                                    abort_error_bit = 1'b1;
                                end else begin
                                    s_d.max = req48; // R5
                                    if (req48 <= MABS_LBA28_MAX) begin
                                        s_d.w6160 = req48[27:0]; // R8
                                    end
                                    if (s_q.seccnt[0]) begin
                                        s_d.nv_max = req48; // R12
                                        s_d.nv_valid = 1'b1;
                                        s_d.nv_used = 1'b1;
                                    end
                                end
                            end
                            MABS_CMD_SETMAX: begin
                                if (s_q.cfg[MABS_CFG_LOCK_BIT] || (s_q.device[MABS_DEV_LBA_BIT]
                                        && req28w > NATIVE_MAX)) begin
                                    abort_error_bit = 1'b1;
                                end else if (s_q.device[MABS_DEV_LBA_BIT]) begin // R1
                                    s_d.max = req28w; // R3
                                    s_d.w6160 = req28;
                                end else begin
                                    s_d.lba_lo = MABS_CHS_SECT; // R4
                                    s_d.device[3:0] = MABS_CHS_HEAD;
                                    s_d.max = {32'h00000000, cyl};
                                end
                            end
                            MABS_CMD_SETMULT: begin
                                if (blk_ok(s_q.seccnt)) begin // R17
                                    s_d.blk = s_q.seccnt; // R14
                                end else begin
                                    s_d.blk = 8'h00; // R18
                                    abort_error_bit = 1'b1;
                                end
                            end
                            default: begin
                            end
                        endcase
                        if (abort_error_bit) begin
                            s_d.error[MABS_ER_ABT_BIT] = 1'b1; // R19
                            s_d.status[MABS_ST_ERR_BIT] = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (wb_adr_i)
                MABS_OFF_SECCNT: s_d.rdat = {24'h000000, s_q.seccnt};
                MABS_OFF_LBALO: begin
                    s_d.rdat = {24'h000000, s_q.lba_lo};
                    s_d.hob_rd = s_q.hob; // R13
                end
                MABS_OFF_LBAMID: begin
                    s_d.rdat = {24'h000000, s_q.lba_mid};
                    s_d.hob_rd = s_q.hob;
                end
                MABS_OFF_LBAHI: begin
                    s_d.rdat = {24'h000000, s_q.lba_hi};
                    s_d.hob_rd = s_q.hob;
                end
                MABS_OFF_DEVICE: s_d.rdat = {24'h000000, s_q.device};
                MABS_OFF_STATUS: s_d.rdat = {24'h000000, s_q.status};
                MABS_OFF_ERROR: s_d.rdat = {24'h000000, s_q.error};
                MABS_OFF_CTRL: s_d.rdat = {24'h000000, s_q.hob, 7'h00};
                MABS_OFF_NATLO: s_d.rdat = NATIVE_MAX[31:0];
                MABS_OFF_NATHI: s_d.rdat = {16'h0000, NATIVE_MAX[47:32]};
                MABS_OFF_CFG: s_d.rdat = {27'h0, s_q.cfg};
                MABS_OFF_MAXLO: s_d.rdat = s_q.max[31:0];
                MABS_OFF_MAXHI: s_d.rdat = {16'h0000, s_q.max[47:32]};
                MABS_OFF_W6160: s_d.rdat = {4'h0, s_q.w6160};
                MABS_OFF_BLK: s_d.rdat = {24'h000000, s_q.blk};
                default: s_d.rdat = 32'h00000000;
            endcase
        end
        // Power-on reset keeps only a non-volatile max; the volatile max and block size go
        if (por_i) begin
            s_d.max = s_q.nv_valid ? s_q.nv_max : NATIVE_MAX; // R12
            s_d.blk = MABS_BLK_RST; // R16
            s_d.nv_used = 1'b0; // R11
            s_d.last_rdnat = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.status <= MABS_STATUS_RST;
            s_q.max <= NATIVE_MAX;
            s_q.cfg <= MABS_CFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    // Both sources are registers; the select only picks the shadow for HOB reads
    assign wb_dat_o = s_q.hob_rd ? {24'h000000, sh_rdata} : s_q.rdat; // R13
    assign access_abort_o = s_q.abort_acc;
    assign blk_sectors_o = s_q.blk[4:0]; // R15
    assign multi_en_o = s_q.blk != 8'h00; // R16

    // Command checks key on cmd_go so they follow exactly what the decoder accepts
    AST_BLK_VALID: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        blk_ok(s_q.blk)) else $error("Block size illegal");
    AST_ABT_PAIR: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        s_q.error[MABS_ER_ABT_BIT] |-> s_q.status[MABS_ST_ERR_BIT]
        && s_q.status[MABS_ST_RDY_BIT]) else $error("Abort without err");
    AST_BAD_BLK: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        (cmd_go && cmd == MABS_CMD_SETMULT && !blk_ok(s_q.seccnt) && !por_i)
        |=> (s_q.blk == 8'h00 && s_q.error[MABS_ER_ABT_BIT]))
        else $error("Bad size accepted");
    AST_EXT_NEEDS_RDNAT: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (cmd_go && cmd == MABS_CMD_SETMAX_EXT && !s_q.last_rdnat)
        |=> s_q.error[MABS_ER_ABT_BIT]) else $error("No rdnat");
    AST_OVER_NATIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (cmd_go && cmd == MABS_CMD_SETMAX_EXT && req48 > NATIVE_MAX)
        |=> s_q.error[MABS_ER_ABT_BIT]) else $error("Set max above native");
    AST_OFFS_NV: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (cmd_go && cmd == MABS_CMD_SETMAX_EXT && s_q.seccnt[0] && s_q.cfg[MABS_CFG_OFFS_BIT])
        |=> s_q.error[MABS_ER_ABT_BIT]) else $error("Non-volatile in offset mode");
    AST_W28_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (cmd_go && cmd == MABS_CMD_SETMAX_EXT && req48 > MABS_LBA28_MAX)
        |=> s_q.w6160 == $past(s_q.w6160)) else $error("Words 61:60 changed");
    AST_NV_ONCE: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        (cmd_go && cmd == MABS_CMD_SETMAX_EXT && s_q.seccnt[0] && s_q.nv_used)
        |=> s_q.status[MABS_ST_ERR_BIT]) else $error("Second nv");
    AST_NV_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        por_i |=> !s_q.nv_used) else $error("Non-volatile lock kept over power-on");
    AST_NV_POR: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        (por_i && s_q.nv_valid) |=> s_q.max == $past(s_q.nv_max))
        else $error("Max lost at power-on");
    AST_POR_BLK: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        por_i |=> (s_q.blk == MABS_BLK_RST && !multi_en_o)) else $error("Block size kept");
    AST_CHS_RESULT: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (cmd_go && cmd == MABS_CMD_SETMAX && !s_q.device[MABS_DEV_LBA_BIT]
        && !s_q.cfg[MABS_CFG_LOCK_BIT]) |=> (s_q.lba_lo == MABS_CHS_SECT
        && s_q.device[3:0] == MABS_CHS_HEAD)) else $error("CHS result wrong");
    AST_ACC_ABORT: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (access_req_i && access_lba_i > s_q.max) |=> access_abort_o)
        else $error("Access over max");
    AST_RDNAT_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        (cmd_go && !por_i) |=> s_q.last_rdnat == ($past(cmd) == MABS_CMD_RDNAT_EXT))
        else $error("Flag");
    // Ack is a single-cycle strobe, so a held request is not taken again in its ack cycle
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("Ack held");
endmodule

// File: verification/mabs_host_model.sv
// Host model that drives the task file over classic Wishbone cycles
`timescale 1ns/1ps
module mabs_host_model
    import mabs_pkg::*;
(
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [5:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
        wb_adr_o = 6'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // Request held until ack is seen high; the idle cycle after lets ack drop
    task automatic xfer(input logic we, input logic [5:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, we};
        wb_adr_o <= a;
        wb_sel_o <= 4'h1;
        wb_dat_o <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1) @(posedge clk_i);
        q = wb_dat_i;
        {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    // Previous byte first: each write pushes the old byte into the previous copy
    task automatic set_lba48(input logic [47:0] v);
        wr(MABS_OFF_DEVICE, 8'he0);
        wr(MABS_OFF_LBALO, v[31:24]);
        wr(MABS_OFF_LBALO, v[7:0]);
        wr(MABS_OFF_LBAMID, v[39:32]);
        wr(MABS_OFF_LBAMID, v[15:8]);
        wr(MABS_OFF_LBAHI, v[47:40]);
        wr(MABS_OFF_LBAHI, v[23:16]);
    endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the max-address and block-size command block
`timescale 1ns/1ps
module tb;
    import mabs_pkg::*;
    typedef struct packed {logic [7:0] cnt; logic [7:0] blk; logic ab;} mabs_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b0, slave = 1'b0, req = 1'b0;
    logic [47:0] lba = 48'h0;
    logic abort_o, multi_o, cyc, stb, we, ack;
    logic [3:0] sel;
    logic [4:0] blk_o;
    logic [5:0] adr;
    logic [31:0] dw, dr, q;
    logic [47:0] v = 48'h0000_0123_4567;
    int mismatches = 0;
    int check_count = 0;
    // Invalid sizes follow valid ones so that the disable is visible
    mabs_row_t rows [8] = '{'{8'h04, 8'h04, 1'b0}, '{8'h03, 8'h00, 1'b1},
        '{8'h10, 8'h10, 1'b0}, '{8'h01, 8'h00, 1'b1}, '{8'h08, 8'h08, 1'b0},
        '{8'h20, 8'h00, 1'b1}, '{8'h02, 8'h02, 1'b0}, '{8'h00, 8'h00, 1'b0}};
    logic [9:0] cr [5] = '{{8'h00, 2'b01}, {8'h03, 2'b01}, {8'h05, 2'b01},
        {8'h09, 2'b11}, {8'h09, 2'b00}};

    always #50 clk_i = ~clk_i;

    mabs_top #(.NATIVE_MAX(48'h0000_2000_0000)) mabs_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .por_i(por_i), .drive_is_slave_i(slave), .access_req_i(req), .access_lba_i(lba),
        .access_abort_o(abort_o), .blk_sectors_o(blk_o), .multi_en_o(multi_o),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack));
    mabs_host_model mabs_host_model_inst (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(dr),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(dw));

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [5:0] a, input logic [7:0] d);
        mabs_host_model_inst.wr(a, d);
    endtask
    task automatic r(input logic [5:0] a);
        mabs_host_model_inst.xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic st(input logic ab);
        r(MABS_OFF_ERROR);
        chk(q[7:0], ab ? 8'h04 : 8'h00);
        r(MABS_OFF_STATUS);
        chk(q[7:0], ab ? 8'h41 : 8'h40);
    endtask
    task automatic setx(input logic [47:0] x, input logic b, input logic ab);
        w(MABS_OFF_CMD, MABS_CMD_RDNAT_EXT);
        mabs_host_model_inst.set_lba48(x);
        w(MABS_OFF_SECCNT, {7'h0, b});
        w(MABS_OFF_CMD, MABS_CMD_SETMAX_EXT);
        st(ab);
    endtask
    task automatic acc(input logic [47:0] x, input logic ab);
        @(posedge clk_i);
        req <= 1'b1;
        lba <= x;
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        chk(abort_o, ab);
    endtask
    task automatic rst_pulse();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Write {device, high, mid, low}; expect {head, high, mid, low} back
    task automatic f9(input logic [31:0] wv, input logic [31:0] ev);
        w(MABS_OFF_DEVICE, wv[31:24]);
        w(MABS_OFF_LBALO, wv[7:0]);
        w(MABS_OFF_LBAMID, wv[15:8]);
        w(MABS_OFF_LBAHI, wv[23:16]);
        w(MABS_OFF_CMD, MABS_CMD_SETMAX);
        st(1'b0);
        for (int j = 0; j < 4; j++) begin
            r(MABS_OFF_LBALO + 6'(4 * j));
            chk(q[7:0] & ((j == 3) ? 8'h0f : 8'hff), ev[8 * j +: 8]);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(100 * 20000);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            w(MABS_OFF_SECCNT, rows[i].cnt);
            w(MABS_OFF_DEVICE, 8'ha0);
            w(MABS_OFF_CMD, MABS_CMD_SETMULT);
            st(rows[i].ab);
            r(MABS_OFF_BLK);
            chk(q[7:0], rows[i].blk);
            chk(multi_o, rows[i].blk != 8'h00);
            chk(blk_o, rows[i].blk[4:0]);
        end
        // Other drive selected: the command must not act
        w(MABS_OFF_SECCNT, 8'h04);
        w(MABS_OFF_DEVICE, 8'hb0);
        w(MABS_OFF_CMD, MABS_CMD_SETMULT);
        r(MABS_OFF_BLK);
        chk(q[7:0], 8'h00);
        slave <= 1'b1;
        w(MABS_OFF_CMD, MABS_CMD_SETMULT);
        r(MABS_OFF_BLK);
        chk(q[7:0], 8'h04);
        slave <= 1'b0;
        w(MABS_OFF_STATUS, 8'hff);
        r(MABS_OFF_STATUS);
        chk(q[7:0], 8'h40);
        rst_pulse();
        r(MABS_OFF_BLK);
        chk({q[7:0], multi_o}, 9'h000);
        st(1'b0);
        // Another command between read-native and set-max
        w(MABS_OFF_SECCNT, 8'h00);
        w(MABS_OFF_CMD, MABS_CMD_RDNAT_EXT);
        w(MABS_OFF_CMD, MABS_CMD_SETMULT);
        mabs_host_model_inst.set_lba48(v);
        w(MABS_OFF_CMD, MABS_CMD_SETMAX_EXT);
        st(1'b1);
        setx(v, 1'b0, 1'b0);
        acc(v, 1'b0);
        acc(v + 48'h1, 1'b1);
        r(MABS_OFF_W6160);
        chk(q, v);
        for (int j = 0; j < 6; j++) begin
            w(MABS_OFF_CTRL, (j < 3) ? 8'h80 : 8'h00);
            r(MABS_OFF_LBALO + 6'(4 * (j % 3)));
            chk(q[7:0], 8'(v >> (8 * (j % 3) + ((j < 3) ? 24 : 0))));
        end
        setx(48'h0000_1000_0000, 1'b0, 1'b0);
        r(MABS_OFF_W6160);
        chk(q, v);
        acc(48'h0000_1000_0001, 1'b1);
        setx(48'h0000_2000_0001, 1'b0, 1'b1);
        for (int k = 0; k < 5; k++) begin
            w(MABS_OFF_CFG, cr[k][9:2]);
            setx(48'h0000_0100_0000, cr[k][1], cr[k][0]);
        end
        w(MABS_OFF_CFG, 8'h01);
        setx(48'h0000_0200_0000, 1'b1, 1'b0);
        setx(48'h0000_0300_0000, 1'b1, 1'b1);
        setx(48'h0000_0300_0000, 1'b0, 1'b0);
        w(MABS_OFF_SECCNT, 8'h04);
        w(MABS_OFF_CMD, MABS_CMD_SETMULT);
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        @(posedge clk_i);
        acc(48'h0000_0200_0000, 1'b0);
        acc(48'h0000_0200_0001, 1'b1);
        r(MABS_OFF_BLK);
        chk(q[7:0], 8'h00);
        r(MABS_OFF_MAXLO);
        chk(q, 32'h0200_0000);
        setx(48'h0000_0180_0000, 1'b1, 1'b0);
        rst_pulse();
        f9(32'he1_33_22_11, 32'h01_33_22_11);
        acc(48'h0000_0133_2211, 1'b0);
        acc(48'h0000_0133_2212, 1'b1);
        f9(32'ha0_12_34_55, 32'h0f_12_34_3f);
        r(MABS_OFF_MAXLO);
        chk(q, 32'h0000_1234);
        close_out();
    end
endmodule
